// *** design/epv_pkg.sv ***
package epv_pkg;
  // pulse train shape
  localparam int unsigned PULSE_COUNT      = 25;
  localparam int unsigned CLK_MHZ          = 200;
  localparam int unsigned PULSE_LOW_US     = 100;
  localparam int unsigned PULSE_HIGH_MIN_US = 10;
  localparam int unsigned PULSE_MIN_US     = 90;
  localparam int unsigned PULSE_MAX_US     = 110;
  localparam int unsigned VPP_SETUP_US     = 10;
  // cycles at the 200 MHz clock
  localparam int unsigned PULSE_LOW_CYC    = PULSE_LOW_US * CLK_MHZ;
  localparam int unsigned PULSE_HIGH_CYC   = PULSE_HIGH_MIN_US * CLK_MHZ;
  localparam int unsigned VPP_SETUP_CYC    = VPP_SETUP_US * CLK_MHZ;
  // a strobe low shorter than this is not a programming pulse
  localparam int unsigned PULSE_MIN_CYC    = PULSE_MIN_US * CLK_MHZ;
  // longest legal strobe low, only the checker uses it
  localparam int unsigned PULSE_MAX_CYC    = PULSE_MAX_US * CLK_MHZ;
  localparam logic [12:0] ENC_TABLE_LAST   = 13'h001f;
  localparam logic [12:0] SIG_MAKER_ADDR   = 13'h0030;
  localparam logic [12:0] SIG_PART_ADDR    = 13'h0031;
  localparam int unsigned CODE_WORDS       = 8192;
  localparam int unsigned ENC_WORDS        = 32;
  // mode select pattern {a,b,c,d}
  localparam logic [3:0] MS_SIGNATURE = 4'h0;
  localparam logic [3:0] MS_PGM_CODE  = 4'hb;
  localparam logic [3:0] MS_VERIFY    = 4'h3;
  localparam logic [3:0] MS_PGM_ENC   = 4'ha;
  localparam logic [3:0] MS_PGM_LOCK1 = 4'hf;
  localparam logic [3:0] MS_PGM_LOCK2 = 4'hc;
  // apb register offsets of the programmer
  localparam logic [11:0] REG_CTRL   = 12'h000;
  localparam logic [11:0] REG_ADDR   = 12'h004;
  localparam logic [11:0] REG_WDATA  = 12'h008;
  localparam logic [11:0] REG_STATUS = 12'h00c;
  localparam logic [11:0] REG_RDATA  = 12'h010;
  localparam int unsigned CTRL_GO_BIT = 0;
  localparam int unsigned CTRL_OP_LSB = 1;
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_DONE_BIT = 1;
  typedef enum logic [2:0] {
    EPV_OP_CODE  = 3'h0,
    EPV_OP_ENC   = 3'h1,
    EPV_OP_LOCK1 = 3'h2,
    EPV_OP_LOCK2 = 3'h3,
    EPV_OP_VERIFY = 3'h4,
    EPV_OP_SIG   = 3'h5
  } epv_op_e;
endpackage

// *** design/epv_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface epv_if;
  logic        reset_pin;
  logic        code_fetch_enable_pin;
  logic        program_strobe;
  logic        program_voltage_pin;
  logic        mode_select_a;
  logic        mode_select_b;
  logic        mode_select_c;
  logic        mode_select_d;
  logic [12:0] addr;
  logic [7:0]  p0_host_out;
  logic        p0_host_oe;
  logic [7:0]  p0_dev_out;
  logic        p0_dev_oe;
  logic [7:0]  p0_in;
  // port 0 level: device or host drive, else pull-ups
  assign p0_in = p0_dev_oe ? p0_dev_out : (p0_host_oe ? p0_host_out : 8'hff);
  modport dev (input reset_pin, code_fetch_enable_pin, program_strobe, program_voltage_pin,
               mode_select_a, mode_select_b, mode_select_c, mode_select_d, addr, p0_in,
               output p0_dev_out, p0_dev_oe);
  modport host (output reset_pin, code_fetch_enable_pin, program_strobe, program_voltage_pin,
                mode_select_a, mode_select_b, mode_select_c, mode_select_d, addr,
                p0_host_out, p0_host_oe, input p0_in);
endinterface
`default_nettype wire

// *** design/epv_pulse_count.sv ***
`timescale 1ns/1ps
`default_nettype none
// counts strobe low pulses of at least the minimum width, longer ones too; resets when cleared
module epv_pulse_count
  import epv_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       strobe,
  input  wire logic       clear,
  output logic            full
);
  logic [15:0] low_q, low_d;
  logic [4:0]  cnt_q, cnt_d;
  logic        strb_q, strb_d;

  // measure each low phase, count it on the rising edge if long enough
  always_comb begin
    strb_d = strobe;
    low_d  = strobe ? 16'h0000 : ((low_q == 16'hffff) ? low_q : low_q + 16'h0001);
    cnt_d  = cnt_q;
    if (clear) begin
      cnt_d = 5'h00;
    end else if (strobe && !strb_q && low_q >= 16'(PULSE_MIN_CYC) && cnt_q != 5'(PULSE_COUNT)) begin
      cnt_d = cnt_q + 5'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_q  <= 16'h0000;
      cnt_q  <= 5'h00;
      strb_q <= 1'b1;
    end else begin
      low_q  <= low_d;
      cnt_q  <= cnt_d;
      strb_q <= strb_d;
    end
  end

  assign full = (cnt_q == 5'(PULSE_COUNT));
endmodule
`default_nettype wire

// *** design/epv_device.sv ***
`timescale 1ns/1ps
`default_nettype none
module epv_device
  import epv_pkg::*;
#(
  parameter logic [7:0] SIG_MAKER = 8'h5a, // arbitrary value
  parameter logic [7:0] SIG_PART  = 8'ha5  // arbitrary value
)(
  input  wire logic pclk,
  input  wire logic presetn,
  epv_if.dev        link,
  output logic      lock1_set,
  output logic      lock2_set,
  output logic      enc_set
);
  logic [7:0] code_mem [CODE_WORDS];
  logic [7:0] enc_mem  [ENC_WORDS];
  logic [3:0] ms;
  logic       prog_mode, done, full, seq_clear;
  logic       lock1_q, lock1_d, lock2_q, lock2_d, enc_q, enc_d, done_q, done_d;
  logic       code_we, enc_we;
  logic [7:0] rd_q, rd_d, raw;
  logic       oe_q, oe_d;

  assign ms        = {link.mode_select_a, link.mode_select_b, link.mode_select_c, link.mode_select_d};
  // programming needs reset high, fetch enable low, vpp and strobe pulses
  assign prog_mode = link.reset_pin && !link.code_fetch_enable_pin && link.program_voltage_pin;
  assign seq_clear = !prog_mode || done_q;

  epv_pulse_count u_cnt (
    .pclk    (pclk),
    .presetn (presetn),
    .strobe  (link.program_strobe),
    .clear   (seq_clear),
    .full    (full)
  );

  assign done = full && prog_mode && !done_q;

  // writes commit once a full pulse train arrives
  always_comb begin
    code_we = done && ms == MS_PGM_CODE && !lock1_q && !lock2_q;
    enc_we  = done && ms == MS_PGM_ENC && !lock1_q && !lock2_q
              && link.addr <= ENC_TABLE_LAST;
    lock1_d = lock1_q || (done && ms == MS_PGM_LOCK1);
    lock2_d = lock2_q || (done && ms == MS_PGM_LOCK2);
    enc_d   = enc_q || enc_we;
    done_d  = prog_mode && (done_q || done);                      // one write per train
  end

  always_ff @(posedge pclk) begin
    if (code_we) begin
      code_mem[link.addr] <= link.p0_in;
    end
    if (enc_we) begin
      enc_mem[link.addr[4:0]] <= link.p0_in;
    end
  end

  // verify path; table contents never reach port 0 directly
  always_comb begin
    raw  = code_mem[link.addr];
    rd_d = 8'hff;
    oe_d = 1'b0;
    // read levels: strobe idle high and no programming voltage on the pin
    if (link.reset_pin && !link.code_fetch_enable_pin && link.program_strobe
        && !link.program_voltage_pin) begin
      if (ms == MS_VERIFY && !lock2_q) begin
        oe_d = 1'b1;
        rd_d = enc_q ? ~(raw ^ enc_mem[link.addr[4:0]]) : raw;
      end else if (ms == MS_SIGNATURE) begin
        oe_d = 1'b1;
        if (link.addr == SIG_MAKER_ADDR) begin
          rd_d = SIG_MAKER;
        end else if (link.addr == SIG_PART_ADDR) begin
          rd_d = SIG_PART;
        end else begin
          rd_d = 8'hff;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock1_q <= 1'b0;
      lock2_q <= 1'b0;
      enc_q   <= 1'b0;
      done_q  <= 1'b0;
      rd_q    <= 8'hff;
      oe_q    <= 1'b0;
    end else begin
      lock1_q <= lock1_d;
      lock2_q <= lock2_d;
      enc_q   <= enc_d;
      done_q  <= done_d;
      rd_q    <= rd_d;
      oe_q    <= oe_d;
    end
  end

  assign link.p0_dev_out = rd_q;
  assign link.p0_dev_oe  = oe_q;
  assign lock1_set       = lock1_q;
  assign lock2_set       = lock2_q;
  assign enc_set         = enc_q;
endmodule
`default_nettype wire

// *** design/epv_host.sv ***
`timescale 1ns/1ps
`default_nettype none
// apb-driven programmer: runs one operation per go
module epv_host
  import epv_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  epv_if.host              link
);
  // setup covers the vpp lead time before the first pulse
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_SETUP = 3'h1,
    ST_LOW   = 3'h2,
    ST_HIGH  = 3'h3,
    ST_READ  = 3'h4,
    ST_END   = 3'h5
  } epv_state_e;
  epv_state_e  st_q;
  epv_state_e  st_d;
  logic [15:0] tmr_q;
  logic [15:0] tmr_d;
  logic [4:0]  np_q;
  logic [4:0]  np_d;
  logic [12:0] addr_q;
  logic [12:0] addr_d;
  logic [7:0]  wd_q;
  logic [7:0]  wd_d;
  logic [7:0]  rdat_q;
  logic [7:0]  rdat_d;
  epv_op_e     op_q;
  epv_op_e     op_d;
  logic        done_q;
  logic        done_d;
  logic        wr;
  logic        go;
  logic [3:0]  ms;
  logic        prog;

  // a go is honoured only from idle; writes while busy are dropped
  assign wr = psel && penable && pwrite;
  assign go = wr && paddr == REG_CTRL && pwdata[CTRL_GO_BIT] && st_q == ST_IDLE;

  // sequencer and registers; apb answers with no wait state
  always_comb begin
    st_d   = st_q;
    tmr_d  = tmr_q;
    np_d   = np_q;
    addr_d = addr_q;
    wd_d   = wd_q;
    op_d   = op_q;
    rdat_d = rdat_q;
    done_d = done_q;
    // address and byte are frozen while a train runs
    if (wr && paddr == REG_ADDR && st_q == ST_IDLE) begin
      addr_d = pwdata[12:0];
    end
    if (wr && paddr == REG_WDATA && st_q == ST_IDLE) begin
      wd_d = pwdata[7:0];
    end
    if (go) begin
      op_d   = epv_op_e'(pwdata[CTRL_OP_LSB+2:CTRL_OP_LSB]);
      done_d = 1'b0;
      tmr_d  = 16'(VPP_SETUP_CYC);
      np_d   = 5'h00;
      st_d   = ST_SETUP;
    end else begin
      case (st_q)
        ST_IDLE: begin
          // nothing moves until a go arrives
          st_d = ST_IDLE;
        end
        ST_SETUP: begin
          tmr_d = tmr_q - 16'h0001;
          if (tmr_q == 16'h0000) begin
            if (op_q == EPV_OP_VERIFY || op_q == EPV_OP_SIG) begin
              st_d = ST_READ;
            end else begin
              st_d  = ST_LOW;
              tmr_d = 16'(PULSE_LOW_CYC - 1);
            end
          end
        end
        ST_LOW: begin
          tmr_d = tmr_q - 16'h0001;
          if (tmr_q == 16'h0000) begin
            st_d  = ST_HIGH;
            np_d  = np_q + 5'h01;
            tmr_d = 16'(PULSE_HIGH_CYC - 1);
          end
        end
        ST_HIGH: begin
          tmr_d = tmr_q - 16'h0001;
          if (tmr_q == 16'h0000) begin
            if (np_q == 5'(PULSE_COUNT)) begin
              st_d = ST_END;
            end else begin
              st_d  = ST_LOW;
              tmr_d = 16'(PULSE_LOW_CYC - 1);
            end
          end
        end
        ST_READ: begin
          rdat_d = link.p0_in;
          st_d   = ST_END;
        end
        ST_END: begin
          done_d = 1'b1;
          st_d   = ST_IDLE;
        end
        default: begin
          st_d = ST_IDLE;
        end
      endcase
    end
  end

  // state registers only; next values come from the block above
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q   <= ST_IDLE;
      tmr_q  <= 16'h0000;
      np_q   <= 5'h00;
      addr_q <= 13'h0000;
      wd_q   <= 8'h00;
      op_q   <= EPV_OP_CODE;
      rdat_q <= 8'h00;
      done_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      tmr_q  <= tmr_d;
      np_q   <= np_d;
      addr_q <= addr_d;
      wd_q   <= wd_d;
      op_q   <= op_d;
      rdat_q <= rdat_d;
      done_q <= done_d;
    end
  end

  // mode select pattern per operation
  always_comb begin
    case (op_q)
      EPV_OP_CODE:  ms = MS_PGM_CODE;
      EPV_OP_ENC:   ms = MS_PGM_ENC;
      EPV_OP_LOCK1: ms = MS_PGM_LOCK1;
      EPV_OP_LOCK2: ms = MS_PGM_LOCK2;
      EPV_OP_SIG:   ms = MS_SIGNATURE;
      default:      ms = MS_VERIFY;
    endcase
  end

  // vpp and port 0 drive only while a program train runs
  assign prog = st_q != ST_IDLE && op_q != EPV_OP_VERIFY && op_q != EPV_OP_SIG;
  assign link.reset_pin             = 1'b1;  // clock assumed running
  assign link.code_fetch_enable_pin = 1'b0;
  assign link.program_voltage_pin   = prog;
  assign link.program_strobe        = st_q != ST_LOW;
  assign link.mode_select_a = ms[3];
  assign link.mode_select_b = ms[2];
  assign link.mode_select_c = ms[1];
  assign link.mode_select_d = ms[0];
  assign link.addr        = addr_q;
  assign link.p0_host_out = wd_q;
  assign link.p0_host_oe  = prog;

  // register read mux
  always_comb begin
    case (paddr)
      REG_ADDR:   prdata = {19'h0, addr_q};
      REG_WDATA:  prdata = {24'h0, wd_q};
      REG_STATUS: prdata = {30'h0, done_q, st_q != ST_IDLE};
      REG_RDATA:  prdata = {24'h0, rdat_q};
      REG_CTRL:   prdata = {28'h0, op_q, 1'b0};
      default:    prdata = 32'h0;
    endcase
  end
  // zero wait state: every register answers in its access cycle
  assign pready  = 1'b1;
  // unmapped offsets answer with an error and read data zero
  assign pslverr = psel && penable && !(paddr == REG_CTRL || paddr == REG_ADDR || paddr == REG_WDATA
                   || paddr == REG_STATUS || paddr == REG_RDATA);
endmodule
`default_nettype wire

// *** bench/epv_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
// watches both ends of the programming link
module epv_sva
  import epv_pkg::*;
#(
  parameter logic [7:0] SIG_MAKER = 8'h5a,
  parameter logic [7:0] SIG_PART  = 8'ha5
)(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        reset_pin,
  input wire logic        code_fetch_enable_pin,
  input wire logic        program_strobe,
  input wire logic        program_voltage_pin,
  input wire logic        mode_select_a,
  input wire logic        mode_select_b,
  input wire logic        mode_select_c,
  input wire logic        mode_select_d,
  input wire logic [12:0] addr,
  input wire logic [7:0]  p0_dev_out,
  input wire logic        p0_dev_oe,
  input wire logic        lock1_set,
  input wire logic        lock2_set,
  input wire logic        enc_set
);
  logic [15:0] lo_q;
  logic [15:0] lo_d;
  logic [15:0] hi_q;
  logic [15:0] hi_d;
  logic [3:0]  ms;
  logic        rd_lv;
  // mode pattern and the levels shared by verify and signature reads
  assign ms = {mode_select_a, mode_select_b, mode_select_c, mode_select_d};
  assign rd_lv = reset_pin && !code_fetch_enable_pin && program_strobe && !program_voltage_pin;
  // strobe run lengths; high run saturates since idle gaps are long
  always_comb begin
    lo_d = program_strobe ? 16'h0000 : lo_q + 16'h0001;
    hi_d = !program_strobe ? 16'h0000 : ((hi_q == 16'hffff) ? hi_q : hi_q + 16'h0001);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lo_q <= 16'h0000;
      hi_q <= 16'h0000;
    end else begin
      lo_q <= lo_d;
      hi_q <= hi_d;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  pulse_width_a: assert property ($rose(program_strobe) |->
    lo_q >= 16'(PULSE_MIN_CYC) && lo_q <= 16'(PULSE_MAX_CYC))
    else $error("strobe low width out of range");
  pulse_gap_a: assert property ($fell(program_strobe) |-> hi_q >= 16'(PULSE_HIGH_CYC))
    else $error("strobe high gap too short");
  vpp_held_a: assert property (!program_strobe |-> program_voltage_pin)
    else $error("programming voltage off during pulse");
  pgm_levels_a: assert property (!program_strobe |-> reset_pin && !code_fetch_enable_pin &&
    (ms == MS_PGM_CODE || ms == MS_PGM_ENC || ms == MS_PGM_LOCK1 || ms == MS_PGM_LOCK2))
    else $error("pulse with wrong mode levels");
  addr_steady_a: assert property (program_voltage_pin && $past(program_voltage_pin) |-> $stable(addr))
    else $error("address moved during a train");
  verify_drive_a: assert property ($past(rd_lv && ms == MS_VERIFY && !lock2_set) |-> p0_dev_oe)
    else $error("verify byte not driven");
  lock2_block_a: assert property ($past(lock2_set && ms == MS_VERIFY) |-> !p0_dev_oe)
    else $error("verify driven with lock 2 set");
  table_hidden_a: assert property (p0_dev_oe |-> $past(ms == MS_VERIFY || ms == MS_SIGNATURE))
    else $error("port 0 driven outside read modes");
  enc_frozen_a: assert property ((lock1_set || lock2_set) && $past(lock1_set || lock2_set) |-> $stable(enc_set))
    else $error("table programmed after lock");
  sig_bytes_a: assert property ($past(rd_lv && ms == MS_SIGNATURE) && $stable(addr) &&
    (addr == SIG_MAKER_ADDR || addr == SIG_PART_ADDR) |->
    p0_dev_oe && p0_dev_out == ((addr == SIG_MAKER_ADDR) ? SIG_MAKER : SIG_PART))
    else $error("signature byte wrong");
endmodule
`default_nettype wire

// *** bench/tb_eprom_program_verify_port.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_eprom_program_verify_port;
  import epv_pkg::*;
  localparam logic [7:0] SIG_M = 8'h5a; // arbitrary value
  localparam logic [7:0] SIG_P = 8'hc3; // arbitrary value
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        lock1_set;
  logic        lock2_set;
  logic        enc_set;
  logic [31:0] r;
  logic        e;
  logic [7:0]  v;
  int          n_fail  = 0;
  int          n_tests = 0;
  // 200 MHz
  always #2.5 pclk = ~pclk; // clock never stops during a train
  epv_if epv_if_i ();
  epv_device #(.SIG_MAKER(SIG_M), .SIG_PART(SIG_P)) epv_device_i (.pclk(pclk), .presetn(presetn),
    .link(epv_if_i.dev), .lock1_set(lock1_set), .lock2_set(lock2_set), .enc_set(enc_set));
  epv_host epv_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(epv_if_i.host));
  epv_sva #(.SIG_MAKER(SIG_M), .SIG_PART(SIG_P)) epv_sva_i (.pclk(pclk), .presetn(presetn),
    .reset_pin(epv_if_i.reset_pin), .code_fetch_enable_pin(epv_if_i.code_fetch_enable_pin),
    .program_strobe(epv_if_i.program_strobe), .program_voltage_pin(epv_if_i.program_voltage_pin),
    .mode_select_a(epv_if_i.mode_select_a), .mode_select_b(epv_if_i.mode_select_b),
    .mode_select_c(epv_if_i.mode_select_c), .mode_select_d(epv_if_i.mode_select_d), .addr(epv_if_i.addr),
    .p0_dev_out(epv_if_i.p0_dev_out), .p0_dev_oe(epv_if_i.p0_dev_oe),
    .lock1_set(lock1_set), .lock2_set(lock2_set), .enc_set(enc_set));
  task automatic final_report;
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (i == 16) begin
      n_fail++;
      final_report();
    end
  endtask
  // start one operation and poll for done; a train lasts about 552k cycles
  task automatic op(input epv_op_e o, input logic [12:0] a, input logic [7:0] d);
    int k;
    apb(1'b1, REG_ADDR, {19'h0, a});
    apb(1'b1, REG_WDATA, {24'h0, d});
    apb(1'b1, REG_CTRL, {28'h0, o, 1'b1});
    for (k = 0; k < 700; k++) begin
      repeat (1000) @(posedge pclk);
      apb(1'b0, REG_STATUS, 32'h0);
      if (r[ST_DONE_BIT] === 1'b1) break;
    end
    if (k == 700) begin
      n_fail++;
      final_report();
    end
  endtask
  task automatic rd(input epv_op_e o, input logic [12:0] a);
    op(o, a, 8'h00);
    apb(1'b0, REG_RDATA, 32'h0);
    v = r[7:0];
  endtask
  task automatic t_unmapped;
    apb(1'b0, 12'h020, 32'h0);
    chk("slverr", 8'h01, {7'h0, e});
    chk("unmapped data", 8'h00, r[7:0]);
  endtask
  task automatic t_sig;
    rd(EPV_OP_SIG, SIG_MAKER_ADDR);
    chk("maker", SIG_M, v);
    rd(EPV_OP_SIG, SIG_PART_ADDR);
    chk("part", SIG_P, v);
  endtask
  task automatic t_code;
    op(EPV_OP_CODE, 13'h0005, 8'h3c);
    rd(EPV_OP_VERIFY, 13'h0005);
    chk("code byte", 8'h3c, v);
    chk("enc flag clear", 8'h00, {7'h0, enc_set});
  endtask
  task automatic t_enc;
    op(EPV_OP_ENC, 13'h0005, 8'h96);
    chk("enc flag", 8'h01, {7'h0, enc_set});
    rd(EPV_OP_VERIFY, 13'h0005);
    chk("xnor byte", ~(8'h3c ^ 8'h96), v);
  endtask
  // lock 1 then a code write that must be refused
  task automatic t_lock1;
    op(EPV_OP_LOCK1, 13'h0000, 8'h00);
    chk("lock1", 8'h01, {7'h0, lock1_set});
    op(EPV_OP_CODE, 13'h0005, 8'h00);
    rd(EPV_OP_VERIFY, 13'h0005);
    chk("locked byte", ~(8'h3c ^ 8'h96), v);
  endtask
  task automatic t_lock2;
    op(EPV_OP_LOCK2, 13'h0000, 8'h00);
    chk("lock2", 8'h01, {7'h0, lock2_set});
    rd(EPV_OP_VERIFY, 13'h0005);
    chk("pulled up", 8'hff, v);
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_unmapped();
    t_sig();
    t_code();
    t_enc();
    t_lock1();
    t_lock2();
    final_report();
  end
endmodule
`default_nettype wire
